// [dbd_cfg.svh]
// Purpose: constants for the eight-channel converter board bus decoder
// Assumes: 100 MHz clock, AHB-Lite register access, 32-bit data
// Notes: offsets, nibble field positions, three reset values and nibble codes live here
`ifndef DBD_CFG_SVH
`define DBD_CFG_SVH

// ****************************************************************
// address map
// ****************************************************************
`define DBD_BUS_ADDR_LSB 2
`define DBD_BUS_ADDR_W 12
`define DBD_BOARD_PREFIX 7'h10
`define DBD_HIGH_ADDR_ZERO 18'h00000
`define DBD_STATUS_ADDR 32'h0000_4000

// ****************************************************************
// nibble codes and fields
// ****************************************************************
`define DBD_NIB_REF_ON 4'h7
`define DBD_NIB_REF_OFF 4'h6
`define DBD_NIB_PRESENT 4'hA
`define DBD_NIB_CHAN_BIT 3
`define DBD_NIB_DATA_BIT 0
`define DBD_NIB_CLK_BIT 1
`define DBD_FRAME_BITS 5'h10

// ****************************************************************
// reset values
// ****************************************************************
`define DBD_RST_CHAN 3'h0
`define DBD_RST_REF 1'b0
`define DBD_RST_CS_N 8'hFF

`endif

// [dbd_pkg.sv]
// Purpose: shared types of the converter board bus decoder
// Assumes: dbd_cfg.svh supplies the numeric constants
// Notes: operation codes follow the two low bus address bits
package dbd_pkg;

    // operation selected by the two low address bits
    typedef enum logic [1:0] {
        DBD_OP_DAC = 2'h0,
        DBD_OP_EEPROM = 2'h1,
        DBD_OP_SELECT = 2'h2,
        DBD_OP_NONE = 2'h3
    } dbd_op_t;

    // serial frame tracker, one-hot
    typedef enum logic [1:0] {
        DBD_FR_IDLE = 2'b01,
        DBD_FR_SHIFT = 2'b10
    } dbd_frame_t;

    // whole state of the top module
    typedef struct packed {
        logic wr_pend;
        dbd_op_t wr_op;
        logic hready_out;
        logic [31:0] rdata;
        logic ref_on;
        logic [2:0] chan;
        logic dac_sdata;
        logic dac_sclk;
        logic [7:0] dac_cs_n;
        logic [7:0] dac_load;
        logic [4:0] bit_cnt;
        dbd_frame_t frame;
        logic ee_sclk;
        logic ee_sda_oe;
        logic [15:0] frames_done;
    } dbd_state_t;

endpackage

// [dbd_sync.sv]
// Purpose: three-stage synchroniser with agreement filter for pin inputs
// Assumes: inputs are asynchronous to clock
// Notes: the output moves only once stages two and three agree
module dbd_sync #(
    parameter int W = 1
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] filt;
    } dbd_sync_state_t;

    dbd_sync_state_t sync_q;
    dbd_sync_state_t sync_d;

    // stage one feeds stage two only; the filter sees stages two and three
    always_comb begin
        sync_d = sync_q;
        sync_d.s1 = async_in;
        sync_d.s2 = sync_q.s1;
        sync_d.s3 = sync_q.s2;
        for (int i = 0; i < W; i++) begin
            if (sync_q.s2[i] == sync_q.s3[i]) begin
                sync_d.filt[i] = sync_q.s3[i];
            end
        end
    end

    // ones at reset: open jumpers and a released data line both read high
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sync_q <= '1;
        end else begin
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q.filt;

endmodule

// [dbd_top.sv]
// Purpose: bus decoder of an eight-channel converter expansion board
// Assumes: host cycles arrive as AHB-Lite single word transfers
// Notes: bus address sits in haddr[13:2], nibble data in bits 3:0
//        a private status word sits at a fixed address above the board window
//
// Added by the designer: the AHB-Lite register port and the register addresses.
`include "dbd_cfg.svh"

module dbd_top (
    input wire logic clock,
    input wire logic sys_rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // jumper header, open pin reads one
    input wire logic [2:0] board_id_jumper_header,
    // converter serial port
    output logic dac_sdata,
    output logic dac_sclk,
    output logic [7:0] dac_cs_n,
    output logic [7:0] dac_load,
    output logic output_reference_switch,
    // calibration eeprom, open-drain data
    output logic eeprom_sclk,
    input wire logic eeprom_sda_in,
    output logic eeprom_sda_out,
    output logic eeprom_sda_oe
);
    import dbd_pkg::*;

    // whole state and its next value
    dbd_state_t st_q;
    dbd_state_t st_d;

    // synchronised pins
    logic [2:0] jumper_s;
    logic ee_sda_s;

    // address decode
    logic [`DBD_BUS_ADDR_W-1:0] bus_addr;
    logic board_hit;
    logic status_hit;
    logic addr_phase;
    dbd_op_t op_sel;
    logic [3:0] nib;
    // read word prepared during the address phase
    logic [31:0] rd_word;

    // host clock edges, select codes and frame end
    logic clk_rise;
    logic clk_fall;
    logic sel_chan;
    logic sel_ref_on;
    logic sel_ref_off;
    logic frame_last;
    // one bit per converter channel, high for the selected one
    logic [7:0] chan_onehot;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************

    // jumpers and eeprom data come from outside the clock domain
    dbd_sync #(
        .W(4)
    ) u_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .async_in({board_id_jumper_header, eeprom_sda_in}),
        .sync_out({jumper_s, ee_sda_s})
    );

    // ****************************************************************
    // address decode
    // ****************************************************************

    // a transfer is taken only while the bus is ready and the slot is active
    assign addr_phase = hsel && hready && htrans[1];
    assign bus_addr = haddr[`DBD_BUS_ADDR_LSB +: `DBD_BUS_ADDR_W];
    assign op_sel = dbd_op_t'(bus_addr[1:0]);
    assign nib = hwdata[3:0];

    // board match: nothing above the window, prefix, then the jumper bits;
    // jumpers are compared after the synchroniser, so a board whose
    // jumpers move answers only once the new value has settled
    always_comb begin
        board_hit = 1'b0;
        status_hit = 1'b0;
        if (haddr[31:14] != `DBD_HIGH_ADDR_ZERO) begin
            // only the private status word lives above the window
            status_hit = (haddr == `DBD_STATUS_ADDR);
        end else if (haddr[1:0] != 2'h0) begin
            // unaligned byte lanes never address a board
            board_hit = 1'b0;
        end else if (bus_addr[11:5] != `DBD_BOARD_PREFIX) begin
            // some other kind of board on the same bus
            board_hit = 1'b0;
        end else if (bus_addr[4:2] != jumper_s) begin
            // same kind of board, other jumper setting
            board_hit = 1'b0;
        end else begin
            board_hit = 1'b1;
        end
    end

    // edges of the host clock bit only matter in data mode
    assign clk_rise = !st_q.dac_sclk && nib[`DBD_NIB_CLK_BIT];
    assign clk_fall = st_q.dac_sclk && !nib[`DBD_NIB_CLK_BIT];

    // select nibble decode; any other code is ignored
    always_comb begin
        sel_chan = 1'b0;
        sel_ref_on = 1'b0;
        sel_ref_off = 1'b0;
        if (nib[`DBD_NIB_CHAN_BIT]) begin
            sel_chan = 1'b1;
        end else if (nib == `DBD_NIB_REF_ON) begin
            sel_ref_on = 1'b1;
        end else if (nib == `DBD_NIB_REF_OFF) begin
            sel_ref_off = 1'b1;
        end
    end
    // the sixteenth falling clock closes the frame
    assign frame_last = (st_q.bit_cnt == `DBD_FRAME_BITS - 5'h1);

    // ****************************************************************
    // channel decode
    // ****************************************************************

    // one select and one load line per converter; only the registered
    // channel number is decoded, so a select write cannot glitch a frame
    for (genvar k = 0; k < 8; k++) begin : g_chan
        assign chan_onehot[k] = (st_q.chan == 3'(k));
    end

    // ****************************************************************
    // read data
    // ****************************************************************

    // read word chosen by address class, then by operation bits;
    // every read that is not ours returns zero, never stale data
    always_comb begin
        rd_word = '0;
        if (board_hit && op_sel == DBD_OP_EEPROM) begin
            rd_word[0] = ee_sda_s;
        end else if (board_hit && op_sel == DBD_OP_SELECT) begin
            rd_word[3:0] = `DBD_NIB_PRESENT;
        end else if (status_hit) begin
            // status: frames done, bit count, frame open, reference, channel
            rd_word[31:16] = st_q.frames_done;
            rd_word[12:8] = st_q.bit_cnt;
            rd_word[7] = (st_q.frame == DBD_FR_SHIFT);
            rd_word[6] = st_q.ref_on;
            rd_word[2:0] = st_q.chan;
        end
    end

    // ****************************************************************
    // next state
    // ****************************************************************

    // zero wait states: a write is remembered at its address edge
    // and acts on the nibble of its data phase; the effect shows
    // in the outputs at the edge that ends that data phase
    always_comb begin
        st_d = st_q;
        st_d.hready_out = 1'b1;
        st_d.dac_load = '0;

        // address phase: decode, prepare read data, remember writes
        if (addr_phase) begin
            st_d.rdata = '0;
            st_d.wr_pend = 1'b0;
            st_d.wr_op = DBD_OP_NONE;
            if (!hwrite) begin
                // reads take the word chosen by the read mux
                st_d.rdata = rd_word;
            end else if (board_hit) begin
                // writes act in their data phase
                st_d.wr_pend = 1'b1;
                st_d.wr_op = op_sel;
            end
        end else if (hready) begin
            st_d.wr_pend = 1'b0;
        end

        // data phase of a write that hit this board
        if (st_q.wr_pend) begin
            case (st_q.wr_op)
                DBD_OP_DAC: begin
                    // bits move one per clock pulse, never as a word
                    st_d.dac_sdata = nib[`DBD_NIB_DATA_BIT];
                    st_d.dac_sclk = nib[`DBD_NIB_CLK_BIT];
                    case (st_q.frame)
                        DBD_FR_IDLE: begin
                            // frame opens on the first data write
                            st_d.frame = DBD_FR_SHIFT;
                            st_d.bit_cnt = '0;
                            st_d.dac_cs_n = ~chan_onehot;
                        end
                        DBD_FR_SHIFT: begin
                            // a falling clock completes one bit
                            if (clk_fall) begin
                                if (frame_last) begin
                                    st_d.frame = DBD_FR_IDLE;
                                    st_d.bit_cnt = '0;
                                    st_d.dac_cs_n = `DBD_RST_CS_N;
                                    st_d.dac_load = chan_onehot;
                                    st_d.frames_done = st_q.frames_done + 16'h1;
                                end else begin
                                    st_d.bit_cnt = st_q.bit_cnt + 5'h1;
                                end
                            end else if (clk_rise) begin
                                st_d.bit_cnt = st_q.bit_cnt;
                            end
                        end
                        default: begin
                            st_d.frame = DBD_FR_IDLE;
                        end
                    endcase
                end
                DBD_OP_EEPROM: begin
                    // open drain: pull low for zero, release for one
                    st_d.ee_sda_oe = !nib[`DBD_NIB_DATA_BIT];
                    st_d.ee_sclk = nib[`DBD_NIB_CLK_BIT];
                end
                DBD_OP_SELECT: begin
                    if (sel_chan) begin
                        // a channel change aborts any partial frame
                        st_d.chan = nib[2:0];
                        st_d.frame = DBD_FR_IDLE;
                        st_d.bit_cnt = '0;
                        st_d.dac_cs_n = `DBD_RST_CS_N;
                    end else if (sel_ref_on) begin
                        st_d.ref_on = 1'b1;
                    end else if (sel_ref_off) begin
                        st_d.ref_on = 1'b0;
                    end
                end
                default: begin
                    st_d.wr_op = DBD_OP_NONE;
                end
            endcase
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************

    // reset leaves the reference off so every output stays disabled
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st_q.wr_pend <= 1'b0;
            st_q.wr_op <= DBD_OP_NONE;
            st_q.hready_out <= 1'b1;
            st_q.rdata <= 32'h0000_0000;
            st_q.ref_on <= `DBD_RST_REF;
            st_q.chan <= `DBD_RST_CHAN;
            st_q.dac_sdata <= 1'b0;
            st_q.dac_sclk <= 1'b0;
            st_q.dac_cs_n <= `DBD_RST_CS_N;
            st_q.dac_load <= 8'h00;
            st_q.bit_cnt <= 5'h00;
            st_q.frame <= DBD_FR_IDLE;
            st_q.ee_sclk <= 1'b0;
            st_q.ee_sda_oe <= 1'b0;
            st_q.frames_done <= 16'h0000;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************

    // all outputs except the constant hresp and eeprom_sda_out come straight from the state register
    // bus side: zero wait states and always an okay response
    assign hreadyout = st_q.hready_out;
    assign hresp = 1'b0;
    assign hrdata = st_q.rdata;

    // converter side
    assign dac_sdata = st_q.dac_sdata;
    assign dac_sclk = st_q.dac_sclk;
    assign dac_cs_n = st_q.dac_cs_n;
    assign dac_load = st_q.dac_load;
    assign output_reference_switch = st_q.ref_on;

    // memory side: the data line is only pulled low, never driven high
    assign eeprom_sclk = st_q.ee_sclk;
    assign eeprom_sda_out = 1'b0;
    assign eeprom_sda_oe = st_q.ee_sda_oe;

endmodule

// [dbd_conv_model.sv]
// Purpose: far-side model of the converters and the calibration memory line
// Assumes: converters shift on a rising serial clock while selected
// Notes: ee_low lets the bench play the memory pulling its data line low
module dbd_conv_model (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic dac_sdata,
    input wire logic dac_sclk,
    input wire logic [7:0] dac_cs_n,
    input wire logic [7:0] dac_load,
    input wire logic eeprom_sda_out,
    input wire logic eeprom_sda_oe,
    input wire logic ee_low,
    output logic eeprom_sda_in,
    output logic [15:0] last_val,
    output logic [2:0] last_ch
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sclk_q;
    logic [15:0] sr_q;
    // open-drain line with pull-up: low only while someone pulls it
    assign eeprom_sda_in = !(eeprom_sda_oe && !eeprom_sda_out) && !ee_low;
    // one bit per rising clock, word taken on the load strobe
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sclk_q <= 1'b0;
            sr_q <= 16'h0;
            last_val <= 16'hFFFF;
            last_ch <= 3'h0;
        end else begin
            sclk_q <= dac_sclk;
            if (dac_sclk && !sclk_q && dac_cs_n != 8'hFF) sr_q <= {sr_q[14:0], dac_sdata};
            for (int k = 0; k < 8; k++) begin
                if (dac_load[k]) begin
                    last_val <= sr_q;
                    last_ch <= k[2:0];
                end
            end
        end
    end
endmodule

// [dbd_top_assertions.sv]
// Purpose: port-level checks of the converter board bus decoder
// Assumes: jumper pins held steady while the board is addressed
// Notes: tracks the bus address phase to judge each data phase
module dbd_chk (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic [2:0] board_id_jumper_header,
    input wire logic dac_sdata,
    input wire logic dac_sclk,
    input wire logic [7:0] dac_cs_n,
    input wire logic [7:0] dac_load,
    input wire logic output_reference_switch,
    input wire logic eeprom_sclk,
    input wire logic eeprom_sda_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic dp_q, dw_q, hit;
    logic [31:0] da_q;
    // remember the address phase so its data phase can be judged
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            dp_q <= 1'b0;
            dw_q <= 1'b0;
            da_q <= 32'h0;
        end else if (hready) begin
            dp_q <= hsel && htrans[1];
            dw_q <= hwrite;
            da_q <= haddr;
        end
    end
    // jumpers read raw: they settle long before the first cycle
    assign hit = da_q[31:14] == 18'h0 && da_q[13:7] == 7'h10
        && da_q[6:4] == board_id_jumper_header && da_q[1:0] == 2'h0;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence wr_s(logic [1:0] m);
        dp_q && dw_q && hit && da_q[3:2] == m;
    endsequence
    ref_on_a: assert property (wr_s(2'h2) ##0 hwdata[3:0] == 4'h7 |=> output_reference_switch)
        else $error("reference not switched on");
    ref_off_a: assert property (wr_s(2'h2) ##0 hwdata[3:0] == 4'h6 |=> !output_reference_switch)
        else $error("reference not switched off");
    present_rd_a: assert property (dp_q && !dw_q && hit && da_q[3:2] == 2'h2 |-> hrdata[3:0] == 4'hA)
        else $error("presence nibble wrong");
    miss_rd_a: assert property (dp_q && !dw_q && !hit && da_q != 32'h4000 |-> hrdata == 32'h0)
        else $error("unmatched read drove data");
    miss_wr_a: assert property (dp_q && dw_q && !hit |=> $stable(output_reference_switch) && $stable(dac_cs_n))
        else $error("unmatched write changed state");
    dac_fwd_a: assert property (wr_s(2'h0) |=> dac_sdata == $past(hwdata[0]) && dac_sclk == $past(hwdata[1]))
        else $error("serial lines not forwarded");
    ee_fwd_a: assert property (wr_s(2'h1) |=> eeprom_sclk == $past(hwdata[1]) && eeprom_sda_oe == !$past(hwdata[0]))
        else $error("memory lines not forwarded");
    load_once_a: assert property (dac_load != 8'h0 |-> $onehot(dac_load) ##1 dac_load == 8'h0 && dac_cs_n == 8'hFF)
        else $error("load strobe malformed");
endmodule

// [tb_dac_board_bus_decoder.sv]
// Purpose: self-checking bench of the converter board bus decoder
// Assumes: board jumpers 101, one word per bus transfer
// Notes: state effects are sampled two edges after a write completes
module tb_dac_board_bus_decoder;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic hsel = 1'b0, hwrite = 1'b0, ee_low = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2, board_id_jumper_header = 3'h5, last_ch;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic hreadyout, hresp, dac_sdata, dac_sclk, output_reference_switch;
    logic eeprom_sclk, eeprom_sda_in, eeprom_sda_out, eeprom_sda_oe;
    logic [7:0] dac_cs_n, dac_load;
    logic [15:0] last_val;
    int err_count = 0, compares = 0, cyc = 0;
    // free-running system clock
    always #5 clock = ~clock;
    dbd_top u_dbd_top (.clock, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hreadyout, .hresp, .hrdata, .board_id_jumper_header, .dac_sdata, .dac_sclk, .dac_cs_n, .dac_load,
        .output_reference_switch, .eeprom_sclk, .eeprom_sda_in, .eeprom_sda_out, .eeprom_sda_oe);
    dbd_conv_model u_dbd_conv_model (.clock, .sys_rst, .dac_sdata, .dac_sclk, .dac_cs_n, .dac_load,
        .eeprom_sda_out, .eeprom_sda_oe, .ee_low, .eeprom_sda_in, .last_val, .last_ch);
    task automatic summarize;
        $display("compares %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic [31:0] ad(input logic [2:0] j, input logic [1:0] m);
        return {18'h0, 7'h10, j, m, 2'h0};
    endfunction
    // one single transfer; address held until hready, data until hready again
    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr2(input logic [1:0] m, input logic [31:0] d);
        bus(ad(3'h5, m), 1'b1, d);
        repeat (2) @(posedge clock);
    endtask
    task automatic t_reset;
        chk("cs_n", dac_cs_n, 8'hFF);
        chk("ref", output_reference_switch, 1'b0);
        chk("load", dac_load, 8'h0);
        chk("ready", hreadyout, 1'b1);
        chk("ee_oe", eeprom_sda_oe, 1'b0);
    endtask
    task automatic t_present;
        bus(ad(3'h5, 2'h2), 1'b0, 32'h0);
        chk("present", rd[3:0], 4'hA);
        bus(ad(3'h5, 2'h3), 1'b0, 32'h0);
        chk("op11 read", rd, 32'h0);
        bus(ad(3'h4, 2'h2), 1'b0, 32'h0);
        chk("other board", rd, 32'h0);
        chk("resp", hresp, 1'b0);
        bus(ad(3'h5, 2'h2) | 32'h0001_0000, 1'b0, 32'h0);
        chk("high address", rd, 32'h0);
    endtask
    task automatic t_ref;
        wr2(2'h2, 32'h7);
        chk("ref on", output_reference_switch, 1'b1);
        bus(ad(3'h4, 2'h2), 1'b1, 32'h6);
        repeat (2) @(posedge clock);
        chk("ref kept", output_reference_switch, 1'b1);
        wr2(2'h2, 32'h6);
        chk("ref off", output_reference_switch, 1'b0);
        wr2(2'h2, 32'h7);
        chk("ref on again", output_reference_switch, 1'b1);
    endtask
    // select a channel, shift a whole word, expect it loaded there
    task automatic t_frame(input logic [2:0] ch, input logic [11:0] v);
        logic [15:0] w;
        w = {4'h0, v};
        wr2(2'h2, {28'h0, 1'b1, ch});
        for (int i = 15; i >= 0; i--) begin
            bus(ad(3'h5, 2'h0), 1'b1, {31'h0, w[i]});
            if (i == 15) begin
                @(posedge clock);
                chk("cs sel", dac_cs_n, {24'h0, ~(8'h01 << ch)});
            end
            bus(ad(3'h5, 2'h0), 1'b1, {30'h0, 1'b1, w[i]});
            bus(ad(3'h5, 2'h0), 1'b1, {31'h0, w[i]});
        end
        repeat (3) @(posedge clock);
        chk("dac word", last_val, w);
        chk("dac chan", last_ch, ch);
        chk("cs idle", dac_cs_n, 8'hFF);
    endtask
    task automatic t_eeprom;
        wr2(2'h1, 32'h0);
        chk("ee oe", eeprom_sda_oe, 1'b1);
        chk("ee sclk", eeprom_sclk, 1'b0);
        wr2(2'h1, 32'h3);
        chk("ee oe off", eeprom_sda_oe, 1'b0);
        chk("ee sclk hi", eeprom_sclk, 1'b1);
        chk("ee out", eeprom_sda_out, 1'b0);
        ee_low <= 1'b1;
        repeat (6) @(posedge clock);
        bus(ad(3'h5, 2'h1), 1'b0, 32'h0);
        chk("ee read low", rd[0], 1'b0);
        ee_low <= 1'b0;
        repeat (6) @(posedge clock);
        bus(ad(3'h5, 2'h1), 1'b0, 32'h0);
        chk("ee read high", rd[0], 1'b1);
    endtask
    // status word after two frames: count 2, idle, reference on, channel 7
    task automatic t_status;
        bus(32'h0000_4000, 1'b0, 32'h0);
        chk("status", rd, 32'h0002_0047);
    endtask
    // main sequence
    initial begin
        repeat (12) @(posedge clock);
        t_reset;
        sys_rst <= 1'b0;
        repeat (5) @(posedge clock);
        t_present;
        t_ref;
        t_frame(3'h0, 12'hA5C);
        t_frame(3'h7, 12'h3C1);
        t_status;
        t_eeprom;
        summarize;
    end
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clock) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            summarize;
        end
    end
endmodule
bind dbd_top dbd_chk u_dbd_chk (.clock, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
    .board_id_jumper_header, .dac_sdata, .dac_sclk, .dac_cs_n, .dac_load, .output_reference_switch,
    .eeprom_sclk, .eeprom_sda_oe);
